// File: logic/ias_pkg.sv
// Constants and types for the incremental converter sequencer
package ias_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] RESULT_OFFSET = 8'h08;
  // Control register fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_DEF_BIT   = 1;
  localparam int CTRL_CONT_BIT  = 2;
  localparam int CTRL_RATIO_LSB = 4;
  localparam int CTRL_ELEM_LSB  = 8;
  localparam int CTRL_RATE_LSB  = 12;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // Status register fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_RES_LSB  = 8;
  // Sequencer timing and result format
  localparam int RATIO_BASE_LOG2 = 3;
  localparam int RES_MAX         = 16;
  localparam logic [15:0] SAT_POS = 16'h7FFF;
  localparam logic [15:0] SAT_NEG = 16'h8000;
  // Oscillator 4 MHz, fastest sampling 500 kHz
  localparam int CLK_HZ       = 125_000_000;
  localparam int OSC_HZ       = 4_000_000;
  localparam int FS_MAX_HZ    = 500_000;
  localparam int OSC_DIV      = CLK_HZ / OSC_HZ;
  localparam int FS_BASE_DIV  = OSC_HZ / FS_MAX_HZ;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_RUN    = 2'b01,
    ST_QUANT  = 2'b10
  } ias_state_type;
endpackage

// File: logic/ias_rate_div.sv
// Sampling-period enable divider from the oscillator rate
`timescale 1ns/1ps
module ias_rate_div
  import ias_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       run,
  input  wire logic [1:0] rate_sel,
  output logic            tick
);
  logic [7:0] osc_cnt_reg;
  logic       osc_tick;
  logic [7:0] fs_cnt_reg;
  logic [7:0] fs_limit;

  // Oscillator emulation: one enable per 4 MHz cycle
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      osc_cnt_reg <= 8'h00;
    end else if (osc_cnt_reg == 8'(OSC_DIV - 1)) begin
      osc_cnt_reg <= 8'h00;
    end else begin
      osc_cnt_reg <= osc_cnt_reg + 8'h01;
    end
  end
  assign osc_tick = run && (osc_cnt_reg == 8'(OSC_DIV - 1));

  // rate field divider
  // Code 11 divides by 8, each step down doubles the period
  assign fs_limit = 8'(FS_BASE_DIV << (2'h3 - rate_sel)) - 8'h01;

  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      fs_cnt_reg <= 8'h00;
      tick       <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (osc_tick) begin
        if (fs_cnt_reg >= fs_limit) begin
          fs_cnt_reg <= 8'h00;
          tick       <= 1'b1;
        end else begin
          fs_cnt_reg <= fs_cnt_reg + 8'h01;
        end
      end
    end
  end
endmodule

// File: logic/ias_seq.sv
// Incremental converter sequencer, result formatter and register slave
// Behaviour
// - elem_count_select 00/01/10/11 gives 1/2/4/8 elementary conversions
// - Resolution is 2*log2(ratio)+log2(count), six to sixteen bits
// - Resolution above sixteen bits is truncated to sixteen
// - Conversion lasts count*(ratio+1)+1 sampling periods
// - One mode bit selects continuous or on-request conversion
// - Continuous mode restarts at once, writes result, pulses trigger
// - On-request conversion starts on start bit, same sequence
// - Result is a sixteen-bit two's-complement word
// - Out of range results clamp to 0x7FFF or 0x8000
// - Non-significant low bits forced to one followed by zeros
// - Significant bits sit at the top of the word
// - Start bit or default-trigger bit starts a conversion
// - Elementary conversion spans ratio+1 periods, offset polarity alternates
// - ratio_select code gives ratio two to the three plus code
// - sample_rate_select gives 62.5, 125, 250 or 500 kHz
`timescale 1ns/1ps
module ias_seq
  import ias_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        mod_bit,
  output logic             offset_polarity,
  output logic             modulator_reset,
  output logic             conv_trigger
);
  ias_state_type state_reg;
  logic [31:0]   ctrl_reg;
  logic          start_req_reg;
  logic [2:0]    ratio_reg;
  logic [1:0]    elem_reg;
  logic [1:0]    rate_reg;
  logic [10:0]   period_cnt_reg;
  logic [3:0]    elem_cnt_reg;
  logic signed [24:0] accum_reg;
  logic signed [24:0] elem_sum_reg;
  logic [15:0]   conversion_result;
  logic          done_reg;
  logic          tick;
  logic          aw_held_reg;
  logic          w_held_reg;
  logic [7:0]    awaddr_reg;
  logic [31:0]   wdata_reg;
  logic          wr_go;
  logic          ctrl_wr;
  logic [3:0]    wstrb_reg;
  logic          busy;
  logic signed [24:0] elem_step;
  logic signed [24:0] elem_total;

  // Log2 of the over-sampling ratio, shared by timing and formatting
  function automatic logic [3:0] ratio_log2(input logic [2:0] r);
    // ratio is two to three plus code
    ratio_log2 = 4'(RATIO_BASE_LOG2) + 4'(r);
  endfunction

  // Resolution in bits from the latched fields, capped at the word size
  function automatic logic [4:0] res_bits(input logic [2:0] r, input logic [1:0] e);
    logic [4:0] n;
    n = 5'(2 * ratio_log2(r)) + 5'(e);
    res_bits = (n > 5'(RES_MAX)) ? 5'(RES_MAX) : n;
  endfunction

  // Full-scale scaling, clamp and forced low bits
  function automatic logic [15:0] fmt_result(input logic signed [24:0] mean,
                                             input logic [2:0] r, input logic [1:0] e);
    logic signed [24:0] scaled;
    logic [15:0]        w;
    logic [15:0]        mask;
    logic [4:0]         n;
    n = res_bits(r, e);
    // full-scale input is half the code span above or below zero
    // Shift by one less than the word width minus log2 of the ratio so the span equals the reference
    scaled = mean <<< (5'(RES_MAX - 1) - 5'(ratio_log2(r)));
    if (scaled > 25'sd32767) begin
      w = SAT_POS;
    end else if (scaled < -25'sd32768) begin
      w = SAT_NEG;
    end else begin
      w = scaled[15:0];
    end
    // one then zeros in the dropped bits
    mask = 16'hFFFF << (5'(RES_MAX) - n);
    if (n < 5'(RES_MAX)) begin
      w = (w & mask) | (16'h0001 << (5'(RES_MAX - 1) - n));
    end
    fmt_result = w;
  endfunction

  // Busy while a conversion runs; also gates the sampling divider
  assign busy = (state_reg != ST_IDLE);

  // Sample of this tick, signed by offset polarity; the wrap tick counts too
  assign elem_step  = (mod_bit ^ offset_polarity) ? 25'sd1 : -25'sd1;
  assign elem_total = elem_sum_reg + elem_step;

  ias_rate_div u_div (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .run      (busy),
    .rate_sel (rate_reg),
    .tick     (tick)
  );

  // Write channel capture, address and data in either order
  // Response waits for both halves; a pending answer blocks the next write
  assign wr_go   = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign ctrl_wr = wr_go && (awaddr_reg == CTRL_OFFSET);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      awaddr_reg    <= 8'h00;
      wdata_reg     <= 32'h0000_0000;
      wstrb_reg     <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_reg == CTRL_OFFSET) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control register; start and default bits self-clear into a request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg      <= CTRL_RESET;
      start_req_reg <= 1'b0;
    end else begin
      // Strobes captured with the data; the master may drop them after handshake
      if (ctrl_wr && wstrb_reg[0]) begin
        ctrl_reg[7:0] <= wdata_reg[7:0] & 8'hFC;
      end
      if (ctrl_wr && wstrb_reg[1]) begin
        ctrl_reg[15:8] <= wdata_reg[15:8];
      end
      // either bit requests a conversion; a new request wins over consume
      if (ctrl_wr && wstrb_reg[0] &&
          (wdata_reg[CTRL_START_BIT] || wdata_reg[CTRL_DEF_BIT])) begin
        start_req_reg <= 1'b1;
      end else if (state_reg == ST_IDLE) begin
        start_req_reg <= 1'b0;
      end
    end
  end

  // Read channel, one cycle answer after the address
  // Status reports the latched resolution, not the one being written
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        case (s_axi_araddr)
          CTRL_OFFSET: begin
            s_axi_rdata <= ctrl_reg;
          end
          STATUS_OFFSET: begin
            s_axi_rdata <= {19'h0, res_bits(ratio_reg, elem_reg), 6'h0,
                            done_reg, busy};
          end
          RESULT_OFFSET: begin
            s_axi_rdata <= {16'h0000, conversion_result};
          end
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Conversion sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg         <= ST_IDLE;
      ratio_reg         <= 3'h0;
      elem_reg          <= 2'h0;
      rate_reg          <= 2'h0;
      period_cnt_reg    <= 11'h000;
      elem_cnt_reg      <= 4'h0;
      accum_reg         <= 25'sd0;
      elem_sum_reg      <= 25'sd0;
      offset_polarity   <= 1'b0;
      modulator_reset   <= 1'b1;
      conversion_result <= 16'h0000;
      conv_trigger      <= 1'b0;
      done_reg          <= 1'b0;
    end else begin
      conv_trigger <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          modulator_reset <= 1'b1;
          // mode bit: continuous runs without a request
          // on-request waits for the start request
          // Continuous uses the live bit, so clearing it stops after this result
          if (start_req_reg || ctrl_reg[CTRL_CONT_BIT]) begin
            // settings frozen for the whole conversion
            ratio_reg       <= ctrl_reg[CTRL_RATIO_LSB +: 3];
            elem_reg        <= ctrl_reg[CTRL_ELEM_LSB +: 2];
            rate_reg        <= ctrl_reg[CTRL_RATE_LSB +: 2];
            period_cnt_reg  <= 11'h000;
            elem_cnt_reg    <= 4'h0;
            accum_reg       <= 25'sd0;
            elem_sum_reg    <= 25'sd0;
            offset_polarity <= 1'b0;
            modulator_reset <= 1'b0;
            state_reg       <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (tick) begin
            // Integrate the modulator bit, sign by offset polarity
            elem_sum_reg <= elem_total;
            if (period_cnt_reg == (11'h001 << ratio_log2(ratio_reg))) begin
              period_cnt_reg  <= 11'h000;
              // Undo the polarity swap so offsets of alternate halves cancel
              accum_reg       <= accum_reg + (offset_polarity ? -elem_total
                                                              : elem_total);
              elem_sum_reg    <= 25'sd0;
              offset_polarity <= !offset_polarity;
              if (elem_cnt_reg == 4'((4'h1 << elem_reg) - 4'h1)) begin
                state_reg <= ST_QUANT;
              end
              elem_cnt_reg <= elem_cnt_reg + 4'h1;
            end else begin
              period_cnt_reg <= period_cnt_reg + 11'h001;
            end
          end
        end
        ST_QUANT: begin
          // one more sampling period for quantization
          if (tick) begin
            // Mean of elementary results, then formatting
            conversion_result <= fmt_result(accum_reg >>> elem_reg, ratio_reg, elem_reg);
            // publish the result with a trigger pulse
            conv_trigger    <= 1'b1;
            done_reg        <= 1'b1;
            modulator_reset <= 1'b1;
            // continuous mode restarts through idle at once
            state_reg       <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// File: test/ias_mod_model.sv
// Behavioural model of the over-sampling modulator bit stream
`timescale 1ns/1ps
module ias_mod_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [1:0] mode,
  input  wire logic       modulator_reset,
  output logic            mod_bit
);
  // Toggles while held in reset, so a stale level is never trusted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mod_bit <= 1'b0;
    end else if (modulator_reset || mode[1]) begin
      mod_bit <= ~mod_bit;
    end else begin
      mod_bit <= mode[0];
    end
  end
endmodule

// File: test/ias_seq_asserts.sv
// Port checks for the converter sequencer
`timescale 1ns/1ps
module ias_seq_asserts
  import ias_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        offset_polarity,
  input wire logic        modulator_reset,
  input wire logic        conv_trigger
);
  logic [15:0] gap_reg;
  logic [15:0] run_reg;
  logic        pol_reg;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Cycles since last result; saturates so the first result is exempt
  always_ff @(posedge aclk) begin
    if (!aresetn) gap_reg <= 16'hFFFF;
    else if (conv_trigger) gap_reg <= 16'h0000;
    else if (gap_reg != 16'hFFFF) gap_reg <= gap_reg + 16'h0001;
  end
  // Cycles since polarity flip or since the modulator left reset
  always_ff @(posedge aclk) begin
    pol_reg <= offset_polarity;
    if (modulator_reset || offset_polarity != pol_reg) run_reg <= 16'h0000;
    else if (run_reg != 16'hFFFF) run_reg <= run_reg + 16'h0001;
  end
  a_trig_single: assert property (conv_trigger |=> !conv_trigger[*3])
    else $error("result pulse too long");
  a_trig_gap: assert property (conv_trigger |-> gap_reg >= 16'h0960)
    else $error("results closer than the shortest conversion");
  a_pol_gap: assert property (offset_polarity != pol_reg && !$past(modulator_reset)
    |-> run_reg >= 16'h0898) else $error("elementary conversion too short");
  a_start_runs: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready && s_axi_awaddr == CTRL_OFFSET && s_axi_wstrb[0] && s_axi_wdata[13]
    && (s_axi_wdata[CTRL_START_BIT] || s_axi_wdata[CTRL_DEF_BIT])
    |-> ##[1:600] !modulator_reset) else $error("start did not release modulator");
  a_run_hold: assert property ($fell(modulator_reset) |=> !modulator_reset[*8])
    else $error("conversion ended at once");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  a_bvalid_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
endmodule
bind ias_seq ias_seq_asserts chk (.*);

// File: test/incremental_adc_sequencer_test.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
module incremental_adc_sequencer_test;
  import ias_pkg::*;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, mode, rs;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        aclk, aresetn, mod_bit, offset_polarity, modulator_reset, conv_trigger;
  int          errors, num_checks, cycles;
  ias_seq uut (.*);
  ias_mod_model model (.*);
  initial aclk = 1'b0;
  always #4 aclk = ~aclk;
  // Hang guard, well above the longest planned sequence
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 90000) begin
      errors++;
      print_verdict();
    end
  end
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int res_of(int r, int e);
    return (2 * (r + 3) + e > RES_MAX) ? RES_MAX : 2 * (r + 3) + e;
  endfunction
  // Clamped code with the low bits forced to one then zeros
  function automatic logic [15:0] sat_of(logic hi, int n);
    logic [15:0] v;
    v = hi ? SAT_POS : SAT_NEG;
    if (n < 16) v = (v & (16'hFFFF << (16 - n))) | (16'h0001 << (15 - n));
    return v;
  endfunction
  task print_verdict;
    if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Ready is raised only once the answer shows, so answers must stand
  task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask
  task rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready));
    d = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task do_reset;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask
  // Waits for a result pulse; a nonzero count checks the duration
  task wait_trig(input int ticks, input int rt);
    int n;
    int t;
    n = 0;
    t = OSC_DIV * FS_BASE_DIV * (1 << (3 - rt));
    do begin
      @(posedge aclk);
      n++;
    end while (conv_trigger !== 1'b1);
    if (ticks > 0) chk(n >= ticks * t - t / 2 && n <= ticks * t + t / 2, 1);
  endtask
  task conv(input int r, e, rt, input logic [31:0] go, input logic [1:0] m, input int ticks);
    mode <= m;
    wr(CTRL_OFFSET, go | 32'(r) << 4 | 32'(e) << 8 | 32'(rt) << 12, RESP_OKAY);
    wait_trig(ticks, rt);
    rd(RESULT_OFFSET);
    if (!m[1]) chk(d[15:0], sat_of(m[0], res_of(r, e)));
    rd(STATUS_OFFSET);
    chk(d[12:0], {5'(res_of(r, e)), 8'h02});
  endtask
  initial begin
    seed = 36619;
    {errors, num_checks, cycles} = 0;
    {mode, s_axi_awaddr, s_axi_araddr, s_axi_wdata, aresetn} = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
    s_axi_wstrb = 4'hF;
    do_reset();
    chk({modulator_reset, conv_trigger}, 2'b10);
    rd(CTRL_OFFSET);
    chk(d, CTRL_RESET);
    rd(8'h0C);
    chk({d, rs}, {32'h0, RESP_SLVERR});
    wr(STATUS_OFFSET, 32'h1, RESP_SLVERR);
    // Every ratio and count code, aborted by reset after the start
    for (int r = 0; r < 8; r++) begin
      for (int e = 0; e < 4; e++) begin
        d = (rnd() & 32'hFFFF_C000) | 32'h3001 | 32'(r) << 4 | 32'(e) << 8;
        wr(CTRL_OFFSET, d, RESP_OKAY);
        rd(STATUS_OFFSET);
        chk(d[12:0], {5'(res_of(r, e)), 8'h01});
        rd(CTRL_OFFSET);
        chk(d[13:0], 14'h3000 | 14'(r) << 4 | 14'(e) << 8);
        do_reset();
      end
    end
    conv(0, 0, 3, 32'h1 << CTRL_START_BIT, 2'b01, 10);
    conv(0, 0, 2, 32'h1 << CTRL_DEF_BIT, 2'b00, 10);
    conv(1, 1, 3, 32'h1, 2'(rnd() & 32'h1), 35);
    conv(4, 0, 3, 32'h1, 2'b01, 130);
    // Continuous run, then mode cleared in mid conversion
    wr(CTRL_OFFSET, 32'h1 << CTRL_CONT_BIT | 32'h3001, RESP_OKAY);
    wait_trig(10, 3);
    wait_trig(10, 3);
    wr(CTRL_OFFSET, 32'h3070, RESP_OKAY);
    wait_trig(10, 3);
    num_checks++;
    repeat (3000) begin
      @(posedge aclk);
      if (conv_trigger) chk(conv_trigger, 0);
    end
    print_verdict();
  end
endmodule
